// file: rtl/pemux_pkg.sv
package pemux_pkg;
    // ------------------------------------------------------------
    // pin map and widths
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 5;
    localparam int BUS_BIT_BASE = 8;
    localparam int PIN_SLAVE_RD = 0;
    localparam int PIN_SLAVE_WR = 1;
    localparam int PIN_SLAVE_CS = 2;
    localparam int PIN_PWM2_D = 0;
    localparam int PIN_PWM2_C = 1;
    localparam int PIN_PWM2_B = 2;
    localparam int PIN_PWM3_C = 3;
    localparam int PIN_PWM3_B = 4;
    localparam logic [4:0] RST_LATCH = 5'h00;
    localparam logic [4:0] RST_DIR = 5'h1f;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // source chosen for a pin's drive, in priority order
    typedef enum logic [4:0] {
        PEMUX_SRC_BUS = 5'h01,
        PEMUX_SRC_PWM = 5'h02,
        PEMUX_SRC_SLAVE = 5'h04,
        PEMUX_SRC_LAT = 5'h08,
        PEMUX_SRC_IN = 5'h10
    } pemux_src_type;
endpackage : pemux_pkg

// file: rtl/pemux_pin.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// one pin: resolve who drives it
// ------------------------------------------------------------
module pemux_pin
    import pemux_pkg::*;
(
    input wire logic bus_en,
    input wire logic bus_out,
    input wire logic bus_read,
    input wire logic pwm_en,
    input wire logic pwm_val,
    input wire logic pwm_tri,
    input wire logic slave_en,
    input wire logic slave_val,
    input wire logic dir,
    input wire logic lat,
    output logic drive_val,
    output logic drive_oe_n,
    output pemux_src_type src
);
    always_comb begin
        drive_val = 1'b0;
        drive_oe_n = 1'b1;
        if (bus_en) begin
            // read phase releases pin for sampling
            src = PEMUX_SRC_BUS;
            drive_val = bus_out;
            drive_oe_n = bus_read;
        end else if (pwm_en) begin
            // pwm beats latch and slave port
            src = PEMUX_SRC_PWM;
            drive_val = pwm_val;
            drive_oe_n = pwm_tri;
        end else if (slave_en) begin
            src = PEMUX_SRC_SLAVE;
            drive_val = slave_val;
            drive_oe_n = 1'b0;
        end else if (!dir) begin
            // latch drives when direction is 0
            src = PEMUX_SRC_LAT;
            drive_val = lat;
            drive_oe_n = 1'b0;
        end else begin
            src = PEMUX_SRC_IN;
        end
    end
endmodule : pemux_pin

// file: rtl/pemux_top.sv
`timescale 1ns/1ps
module pemux_top
    import pemux_pkg::*;
#(
    parameter int NPINS = pemux_pkg::PIN_COUNT
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe_n,
    output logic [4:0] pullup_on,
    output logic [4:0] port_e_pin_state,
    input wire logic [4:0] port_latch,
    input wire logic [4:0] direction_control,
    input wire logic port_e_pullup_enable,
    input wire logic emi_active,
    input wire logic emi_read,
    input wire logic [4:0] emi_addr_data,
    output logic [4:0] emi_data_in,
    input wire logic byte_write_mode,
    input wire logic table_write_instruction,
    input wire logic [7:0] table_latch,
    input wire logic table_pointer_lsb,
    output logic [15:0] bus_ad_out,
    output logic high_byte_write_strobe,
    output logic low_byte_write_strobe,
    input wire logic parallel_slave_port_mode,
    input wire logic [4:0] parallel_slave_port_data,
    output logic slave_read_en,
    output logic slave_write_en,
    output logic slave_chip_sel,
    input wire logic pwm2_en_b,
    input wire logic pwm2_en_c,
    input wire logic pwm2_en_d,
    input wire logic pwm2_channel_b,
    input wire logic pwm2_channel_c,
    input wire logic pwm2_channel_d,
    input wire logic pwm2_shutdown,
    input wire logic pwm3_en_b,
    input wire logic pwm3_en_c,
    input wire logic pwm3_channel_b,
    input wire logic pwm3_channel_c,
    input wire logic pwm3_shutdown,
    input wire logic pwm3_pin_map_select,
    input wire logic shutdown_tri_enable
);
    import pemux_pkg::*;

    // the pin map is fixed at five pins; refuse anything else
    if (NPINS != PIN_COUNT) begin : g_bad_npins
        $error("pemux_top: pin count must be 5");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
    always_comb begin
        sync1_nxt = pin_in;
        sync2_nxt = sync1_r;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 5'h1f;
            sync2_r <= 5'h1f;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // ------------------------------------------------------------
    // per-pin function resolution
    // ------------------------------------------------------------
    logic [4:0] pwm_en, pwm_val, pwm_tri, slave_en;
    logic [4:0] drv_val, drv_oe_n;
    pemux_src_type src [5];
    logic p3_map;

    always_comb begin
        // pwm3 pins need the map select
        p3_map = pwm3_pin_map_select;
        pwm_en = 5'h00;
        pwm_en[PIN_PWM2_D] = pwm2_en_d;
        pwm_en[PIN_PWM2_C] = pwm2_en_c;
        pwm_en[PIN_PWM2_B] = pwm2_en_b;
        pwm_en[PIN_PWM3_C] = pwm3_en_c & p3_map;
        pwm_en[PIN_PWM3_B] = pwm3_en_b & p3_map;
        pwm_val = {pwm3_channel_b, pwm3_channel_c, pwm2_channel_b,
            pwm2_channel_c, pwm2_channel_d};
        pwm_tri = {{2{pwm3_shutdown}}, {3{pwm2_shutdown}}}
            & {5{shutdown_tri_enable}};
        // slave control pins are inputs; slave port never drives here
        slave_en = 5'h00;
    end

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_pin
            pemux_pin u_pin (
                .bus_en(emi_active),
                .bus_out(emi_addr_data[g]),
                .bus_read(emi_read),
                .pwm_en(pwm_en[g]),
                .pwm_val(pwm_val[g]),
                .pwm_tri(pwm_tri[g]),
                .slave_en(slave_en[g]),
                .slave_val(parallel_slave_port_data[g]),
                .dir(direction_control[g]),
                .lat(port_latch[g]),
                .drive_val(drv_val[g]),
                .drive_oe_n(drv_oe_n[g]),
                .src(src[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic [4:0] out_r, out_nxt, oe_r, oe_nxt, pu_r, pu_nxt;
    logic [4:0] st_r, st_nxt, emi_r, emi_nxt;
    logic [15:0] ad_r, ad_nxt;
    logic hi_stb_r, hi_stb_nxt, lo_stb_r, lo_stb_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt, cs_r, cs_nxt;

    always_comb begin
        out_nxt = drv_val;
        oe_nxt = drv_oe_n;
        pu_nxt = direction_control & {5{port_e_pullup_enable}}
            & {5{~emi_active}};
        st_nxt = sync2_r;
        // bus read samples whatever direction says
        emi_nxt = (emi_active && emi_read) ? sync2_r : emi_r;
        if (byte_write_mode && table_write_instruction) begin
            ad_nxt = {table_latch, table_latch};
        end else begin
            ad_nxt = 16'h0000;
        end
        // exactly one strobe by pointer lsb during a byte-mode table write, none otherwise
        hi_stb_nxt = byte_write_mode && table_write_instruction
            && table_pointer_lsb;
        lo_stb_nxt = byte_write_mode && table_write_instruction
            && !table_pointer_lsb;
        // slave controls only read as inputs when dir is 1
        rd_nxt = parallel_slave_port_mode && !emi_active
            && direction_control[PIN_SLAVE_RD] && sync2_r[PIN_SLAVE_RD];
        wr_nxt = parallel_slave_port_mode && !emi_active
            && direction_control[PIN_SLAVE_WR] && sync2_r[PIN_SLAVE_WR];
        cs_nxt = parallel_slave_port_mode && !emi_active
            && direction_control[PIN_SLAVE_CS] && sync2_r[PIN_SLAVE_CS];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_r <= RST_LATCH;
            oe_r <= RST_DIR;
            pu_r <= 5'h00;
            st_r <= 5'h00;
            emi_r <= 5'h00;
            ad_r <= 16'h0000;
            hi_stb_r <= 1'b0;
            lo_stb_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            cs_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pu_r <= pu_nxt;
            st_r <= st_nxt;
            emi_r <= emi_nxt;
            ad_r <= ad_nxt;
            hi_stb_r <= hi_stb_nxt;
            lo_stb_r <= lo_stb_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            cs_r <= cs_nxt;
        end
    end

    assign pin_out = out_r;
    assign pin_oe_n = oe_r;
    assign pullup_on = pu_r;
    assign port_e_pin_state = st_r;
    assign emi_data_in = emi_r;
    assign bus_ad_out = ad_r;
    assign high_byte_write_strobe = hi_stb_r;
    assign low_byte_write_strobe = lo_stb_r;
    assign slave_read_en = rd_r;
    assign slave_write_en = wr_r;
    assign slave_chip_sel = cs_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_bus_drive_wins: assert property (
        @(posedge clk) disable iff (sys_rst)
        emi_active && !emi_read |=> pin_oe_n == 5'h00
        && pin_out == $past(emi_addr_data))
        else $error("bus not driving pins");
    a_bus_read_float: assert property (
        @(posedge clk) disable iff (sys_rst)
        emi_active && emi_read |=> pin_oe_n == 5'h1f)
        else $error("pins driven during bus read");
    a_bus_over_pwm: assert property (
        @(posedge clk) disable iff (sys_rst)
        emi_active && pwm2_en_d |=> pin_out[0] == $past(emi_addr_data[0])
        && pin_oe_n[0] == $past(emi_read))
        else $error("pwm overrode bus");
    a_latch_drive: assert property (
        @(posedge clk) disable iff (sys_rst)
        !emi_active && !pwm_en[4] && !direction_control[4]
        |=> !pin_oe_n[4] && pin_out[4] == $past(port_latch[4]))
        else $error("latch not on pin");
    a_pwm_over_latch: assert property (
        @(posedge clk) disable iff (sys_rst)
        !emi_active && pwm2_en_c && !pwm_tri[1]
        |=> pin_out[1] == $past(pwm2_channel_c) && !pin_oe_n[1])
        else $error("pwm lost to latch");
    a_pwm_tri_state: assert property (
        @(posedge clk) disable iff (sys_rst)
        !emi_active && pwm2_en_b && pwm2_shutdown && shutdown_tri_enable
        |=> pin_oe_n[2])
        else $error("shutdown pin still driven");
    a_pwm3_map: assert property (
        @(posedge clk) disable iff (sys_rst)
        !emi_active && !pwm3_pin_map_select && !direction_control[3]
        |=> pin_out[3] == $past(port_latch[3]) && !pin_oe_n[3])
        else $error("pwm3 mapped without select");
    a_byte_dup: assert property (
        @(posedge clk) disable iff (sys_rst)
        byte_write_mode && table_write_instruction
        |=> bus_ad_out == {2{$past(table_latch)}})
        else $error("table latch not duplicated");
    a_one_strobe: assert property (
        @(posedge clk) disable iff (sys_rst)
        byte_write_mode && table_write_instruction
        |=> (high_byte_write_strobe ^ low_byte_write_strobe)
        && high_byte_write_strobe == $past(table_pointer_lsb))
        else $error("wrong write strobe");
    a_rd_needs_dir: assert property (
        @(posedge clk) disable iff (sys_rst)
        !direction_control[0] |=> !slave_read_en)
        else $error("slave read with output direction");
    a_pwm_src_order: assert property (
        @(posedge clk) disable iff (sys_rst)
        src[2] == PEMUX_SRC_PWM && !pwm_tri[2]
        |=> !pin_oe_n[2] && pin_out[2] == $past(pwm2_channel_b))
        else $error("pwm source not on pin");
endmodule : pemux_top

// file: tb/pemux_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far side: host, memory and pull-ups
// ----------------------------------------
module pemux_far_model (
    input wire logic clk,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe_n,
    input wire logic [4:0] pullup_on,
    input wire logic [4:0] ext_drv,
    input wire logic [4:0] ext_val,
    output logic [4:0] pin_in
);
    logic [4:0] last_r = 5'h00;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_drv[i]) pin_in[i] = ext_val[i];
            else if (pullup_on[i]) pin_in[i] = 1'b1;
            else pin_in[i] = ~last_r[i];
        end
    end
    // a floating pin must not keep its old level
    always @(posedge clk) last_r <= pin_in;
endmodule : pemux_far_model

// file: tb/port_e_pin_function_mux_tb_top.sv
`timescale 1ns/1ps
module port_e_pin_function_mux_tb_top;
    import pemux_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1;
    logic [4:0] lat, dirc, ead, psd, xd, xv, pin_in, po, oe, pu, pst, eo, eq;
    logic pue, ea, er, bwm, twi, tpl, pspm, sd2, sd3, msel, sdt, wh, wl;
    logic [4:0] ed, eh;
    logic [2:0] pc;
    bit ehv = 1'b0;
    logic [7:0] tl;
    logic [2:0] e2, c2;
    logic [1:0] e3, c3;
    logic [15:0] bad, ebad;
    logic [14:0] ph;
    int miscompares = 0, checks_done = 0, cyc = 0, seed = 32'hbf62, ok = 0;
    initial forever #4 clk = ~clk;
    always @(posedge clk) ph <= {ph[9:0], pin_in};
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    pemux_far_model u_pemux_far_model (.clk(clk), .pin_out(po),
        .pin_oe_n(oe), .pullup_on(pu), .ext_drv(xd), .ext_val(xv),
        .pin_in(pin_in));
    pemux_top u_pemux_top (.clk(clk), .sys_rst(sys_rst), .pin_in(pin_in),
        .pin_out(po), .pin_oe_n(oe), .pullup_on(pu),
        .port_e_pin_state(pst), .port_latch(lat), .direction_control(dirc),
        .port_e_pullup_enable(pue), .emi_active(ea), .emi_read(er),
        .emi_addr_data(ead), .emi_data_in(ed), .byte_write_mode(bwm),
        .table_write_instruction(twi), .table_latch(tl),
        .table_pointer_lsb(tpl), .bus_ad_out(bad),
        .high_byte_write_strobe(wh), .low_byte_write_strobe(wl),
        .parallel_slave_port_mode(pspm), .parallel_slave_port_data(psd),
        .slave_read_en(pc[0]), .slave_write_en(pc[1]),
        .slave_chip_sel(pc[2]), .pwm2_en_b(e2[0]), .pwm2_en_c(e2[1]),
        .pwm2_en_d(e2[2]), .pwm2_channel_b(c2[0]), .pwm2_channel_c(c2[1]),
        .pwm2_channel_d(c2[2]), .pwm2_shutdown(sd2), .pwm3_en_b(e3[0]),
        .pwm3_en_c(e3[1]), .pwm3_channel_b(c3[0]), .pwm3_channel_c(c3[1]),
        .pwm3_shutdown(sd3), .pwm3_pin_map_select(msel),
        .shutdown_tri_enable(sdt));
    // ----------------------------------------
    // expectation and checks
    // ----------------------------------------
    function automatic logic [4:0] pwm_on();
        return {e3[0] & msel, e3[1] & msel, e2[0], e2[1], e2[2]};
    endfunction : pwm_on
    function automatic logic [9:0] exp_pins();
        logic [4:0] en, v, sd, o, q;
        en = pwm_on();
        v = {c3[0], c3[1], c2[0], c2[1], c2[2]};
        sd = {sd3, sd3, sd2, sd2, sd2} & {5{sdt}};
        for (int i = 0; i < 5; i++) begin
            if (ea) {o[i], q[i]} = {er, ead[i]};
            else if (en[i]) {o[i], q[i]} = {sd[i], v[i]};
            else {o[i], q[i]} = {dirc[i], lat[i]};
        end
        return {o, q};
    endfunction : exp_pins
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic step(input logic [31:0] a, input logic [31:0] b);
        @(negedge clk);
        if (ok > 1) begin
            cmp(oe, eo);
            cmp(po & ~eo, eq & ~eo);
            cmp(bad, ebad);
            cmp({wh, wl}, {bwm & twi & tpl, bwm & twi & ~tpl});
            cmp(pu, dirc & {5{pue & ~ea}});
            cmp(pc, {3{pspm & ~ea}} & dirc[2:0] & ph[12:10]);
            if (ea & er) begin
                eh = ph[14:10];
                ehv = 1'b1;
            end
            if (ehv) cmp(ed, eh);
        end
        if (ok > 4) cmp(pst, ph[14:10]);
        ok++;
        {lat, dirc, ead, psd, pue, ea, er, bwm, twi, tpl, pspm} = a[26:0];
        {tl, e2, c2, sd2, sd3, msel, sdt, e3, c3, xd, xv} = b;
        ea = ea & a[27];
        // pwm pins are used with direction 0 only
        dirc = dirc & ~pwm_on();
        {eo, eq} = exp_pins();
        ebad = (bwm & twi) ? {tl, tl} : 16'h0000;
    endtask : step
    task automatic report_and_stop();
        $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] ca [4] = '{32'hffffffff, 32'hffffffef, 32'h07ffffff,
            32'h00000000};
        logic [31:0] cb [4] = '{32'hffffffff, 32'hffffbfff, 32'hffff7fff,
            32'ha5000000};
        {lat, dirc, ead, psd, xd, xv, tl, e2, c2, e3, c3} = '0;
        {pue, ea, er, bwm, twi, tpl, pspm, sd2, sd3, msel, sdt} = '0;
        repeat (12) @(negedge clk);
        cmp({po, oe}, 10'h01f);
        sys_rst = 1'b0;
        foreach (ca[i]) foreach (cb[j]) step(ca[i], cb[j]);
        repeat (2000) step($random(seed), $random(seed));
        step(32'h0, 32'h0);
        report_and_stop();
    end
endmodule : port_e_pin_function_mux_tb_top
